/* bench/la_capture_assertions.sv */
// Checker for the capture engine, bound to every la_capture.
// Assumes one clock pclk and the asynchronous reset presetn.
module la_capture_assertions (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        ce,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [12:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [2:0]  ch_in,
  input wire logic        capture_busy,
  input wire logic        capture_done
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ------------------------------------------------------------
  // Events
  // ------------------------------------------------------------
  // A run write is the only cause allowed to clear the done flag.
  wire logic setup_c = psel && !penable && ce;
  wire logic run_acc = psel && penable && pready && pwrite &&
                       paddr == la_pkg::OFS_CTRL && pwdata[0];

  chk_ready_setup: assert property (setup_c |=> pready)
    else $error("pready missing after setup");
  chk_ready_access: assert property (pready |-> psel && penable)
    else $error("pready outside an access");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held two cycles");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  chk_mem_write: assert property (setup_c && pwrite && paddr[12] |=> pslverr)
    else $error("record write not refused");
  // Byte lanes below the word are not decoded, so only the word counts.
  chk_unmapped_err: assert property (setup_c && !paddr[12] &&
    paddr[11:4] != 8'h00 |=> pslverr)
    else $error("unmapped access not refused");
  chk_mapped_ok: assert property (setup_c && paddr[12:4] == 9'h000 &&
    paddr[1:0] == 2'h0 |=> !pslverr)
    else $error("register access refused");
  chk_run_busy: assert property (run_acc |-> ##2 capture_busy)
    else $error("busy not raised after run");
  chk_done_excl: assert property (capture_done |-> !capture_busy)
    else $error("busy and done together");
  chk_busy_end: assert property ($fell(capture_busy) |-> capture_done)
    else $error("busy ended without done");
  chk_done_hold: assert property ($fell(capture_done) |->
    $past(run_acc) || $past(run_acc, 2))
    else $error("done cleared without run");

  cov_run: cover property (run_acc);
  cov_done: cover property ($rose(capture_done));
  cov_err: cover property (pslverr);
endmodule

/* bench/target_signals.sv */
// Model of the target circuit whose three signals are monitored.
// Assumes it shares pclk with the analyzer; values change after edges.
module target_signals (
  input  wire logic       pclk,
  input  wire logic       presetn,
  output logic      [2:0] ch_in
);
  timeunit 1ns;
  timeprecision 1ns;

  // The pattern counts modulo 7, so that delays of 1000 and 2000
  // samples, both multiples of 8, still give values that differ.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ch_in <= 3'h0;
    end else begin
      ch_in <= (ch_in == 3'h6) ? 3'h0 : ch_in + 3'h1;
    end
  end
endmodule

/* bench/testbench.sv */
// Self-checking bench for la_capture driven by a target model.
// Assumes la_pkg is compiled first; pclk runs at 20 MHz.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;

  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        ce      = 1'b1;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [12:0] paddr   = 13'h0000;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [2:0]  ch_in;
  logic        capture_busy;
  logic        capture_done;
  logic [31:0] rd;
  logic        er;
  logic [2:0]  rec [1024];
  int          err_count = 0;
  int          tests_run = 0;

  `define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin \
    err_count++; $display("FAIL %s exp %0h got %0h", n, e, g); end end

  always #25 pclk = ~pclk;

  // The clock enable stays high except in the freeze scenario.
  la_capture la_capture_inst (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ch_in(ch_in), .capture_busy(capture_busy),
    .capture_done(capture_done));
  target_signals target_signals_inst (.pclk(pclk), .presetn(presetn),
    .ch_in(ch_in));

  // ------------------------------------------------------------
  // Bus and capture helpers
  // ------------------------------------------------------------
  // One APB transfer; only the watchdog ends a wait for pready.
  task automatic apb(input logic w, input logic [12:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Programs a capture, waits for done, and reads the whole record.
  task automatic capture(input logic [8:0] trig, input logic [1:0] pos,
                         input logic [15:0] rate);
    int n;
    apb(1'b1, la_pkg::OFS_TRIG, {23'h0, trig});
    apb(1'b1, la_pkg::OFS_RATE, {16'h0, rate});
    apb(1'b1, la_pkg::OFS_CTRL, {29'h0, pos, 1'b1});
    repeat (3) @(posedge pclk);
    `CHK("busy", 1'b1, capture_busy)
    rd = 32'h0;
    for (n = 0; n < 20000 && rd[1] !== 1'b1; n++) begin
      apb(1'b0, la_pkg::OFS_STATUS, 32'h0);
    end
    `CHK("done pin", 1'b1, capture_done)
    `CHK("busy end", 1'b0, capture_busy)
    for (n = 0; n < 1024; n++) begin
      apb(1'b0, 13'(13'h1000 + 4 * n), 32'h0);
      rec[n] = rd[2:0];
    end
  endtask

  // The target counts modulo 7 each cycle, so word i is known exactly.
  task automatic chk_rec(input int idx, input int val, input int step);
    for (int i = 0; i < 1024; i++) begin
      `CHK("record", 3'((val + (i - idx) * step + 28672) % 7), rec[i])
    end
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    apb(1'b0, la_pkg::OFS_RATE, 32'h0);
    `CHK("rate rst", 32'h0000_0014, rd)
    apb(1'b0, la_pkg::OFS_STATUS, 32'h0);
    `CHK("status rst", 32'h0000_0000, rd)
    $display("reset test ended");
  endtask

  // Each entry pins the trigger to one counter value; 1 rises earlier
  // too, but there channel 1 is low, so that edge must not fire.
  task automatic t_codes();
    logic [8:0] trig [3] = '{9'h08B, 9'h100, 9'h054};
    int         val  [3] = '{3, 0, 4};
    for (int k = 0; k < 3; k++) begin
      capture(trig[k], la_pkg::POS_START, 16'h0001);
      chk_rec(0, val[k], 1);
    end
    $display("trigger code test ended");
  endtask

  task automatic t_position();
    capture(9'h08B, la_pkg::POS_CENTRE, 16'h0001);
    chk_rec(512, 3, 1);
    capture(9'h08B, la_pkg::POS_DLY1, 16'h0001);
    chk_rec(0, 2, 1);
    capture(9'h08B, la_pkg::POS_DLY2, 16'h0001);
    chk_rec(0, 1, 1);
    $display("position test ended");
  endtask

  task automatic t_rate();
    capture(9'h08B, la_pkg::POS_START, 16'h0003);
    chk_rec(0, 3, 3);
    $display("rate test ended");
  endtask

  // Refused accesses must leave the finished record untouched.
  task automatic t_errors();
    apb(1'b0, 13'h0010, 32'h0);
    `CHK("unmapped", 1'b1, er)
    apb(1'b1, 13'h1000, 32'h0000_0007);
    `CHK("mem write", 1'b1, er)
    apb(1'b1, la_pkg::OFS_STATUS, 32'hFFFF_FFFF);
    `CHK("status wr", 1'b0, er)
    apb(1'b0, 13'h1000, 32'h0);
    `CHK("held rec", 32'h0000_0003, rd)
    apb(1'b0, la_pkg::OFS_STATUS, 32'h0);
    `CHK("held done", 1'b1, rd[1])
    $display("error test ended");
  endtask

  // A low clock enable must hold a running capture where it stands;
  // code 7 on every channel acts as ignore, so it triggers on the second sample.
  task automatic t_freeze();
    apb(1'b1, la_pkg::OFS_TRIG, 32'h0000_01FF);
    apb(1'b1, la_pkg::OFS_RATE, 32'h0000_0001);
    apb(1'b1, la_pkg::OFS_CTRL, 32'h0000_0001);
    repeat (3) @(posedge pclk);
    ce <= 1'b0;
    repeat (2000) @(posedge pclk);
    `CHK("frozen busy", 1'b1, capture_busy)
    `CHK("frozen done", 1'b0, capture_done)
    ce <= 1'b1;
    rd = 32'h0;
    for (int n = 0; n < 20000 && rd[1] !== 1'b1; n++) begin
      apb(1'b0, la_pkg::OFS_STATUS, 32'h0);
    end
    `CHK("thawed done", 1'b1, capture_done)
    $display("freeze test ended");
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_codes();
    t_position();
    t_rate();
    t_errors();
    t_freeze();
    test_done();
  end

  // Eight captures of about five thousand cycles each; allow double.
  initial begin
    repeat (80000) @(posedge pclk);
    err_count++;
    test_done();
  end
endmodule

bind la_capture la_capture_assertions la_capture_assertions_inst (
  .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .ch_in(ch_in),
  .capture_busy(capture_busy), .capture_done(capture_done));

/* rtl/la_capture.sv */
// Capture engine of a three-channel logic analyzer with an APB slave.
// Assumes channel inputs are synchronous to pclk and that software
// programs rate, trigger and position before writing the run bit.
//
// The APB slave port and the address map were left to the implementer.
module la_capture #(
  parameter int RATE_W = 16
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [12:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [2:0]  ch_in,
  output logic             capture_busy,
  output logic             capture_done
);

  localparam int AW = $clog2(la_pkg::REC_LEN);
  localparam int CW = 12;
  localparam int NC = la_pkg::NUM_CH;

  // -----------------------------------------------------------------------
  // Declarations
  // -----------------------------------------------------------------------
  logic [NC-1:0]       mem [la_pkg::REC_LEN];
  logic [1:0]          pos_q;
  logic [RATE_W-1:0]   rate_q;
  logic [3*NC-1:0]     trig_q;
  logic                run_q;
  la_pkg::cap_state_t  state_q;
  la_pkg::cap_state_t  state_d;
  logic [CW-1:0]       cnt_q;
  logic [CW-1:0]       cnt_d;
  logic [AW-1:0]       wptr_q;
  logic [AW-1:0]       start_q;
  logic [AW-1:0]       start_d;
  logic [NC-1:0]       prev_q;
  logic                prev_ok_q;
  logic                tick;
  logic                hit;
  logic                wr_en;
  logic                sampling;
  logic [CW-1:0]       dly_len;
  logic                setup;
  logic                wr_acc;
  logic                is_mem;
  logic                mapped;
  logic [31:0]         rd_val;

  // Count constants sized to the counter, pointer constants to the address.
  localparam logic [CW-1:0] C_ONE  = CW'(1);
  localparam logic [CW-1:0] C_LAST = CW'(la_pkg::REC_LEN - 1);
  localparam logic [CW-1:0] C_PRE  = CW'(la_pkg::PRE_LEN);
  localparam logic [CW-1:0] C_DLY1 = CW'(la_pkg::DELAY1_SMP);
  localparam logic [CW-1:0] C_DLY2 = CW'(la_pkg::DELAY2_SMP);
  localparam logic [AW-1:0] A_PRE  = AW'(la_pkg::PRE_LEN);
  localparam logic [AW-1:0] A_ONE  = AW'(1);

  // -----------------------------------------------------------------------
  // Helpers
  // -----------------------------------------------------------------------
  // Register offsets are compared on the word address only.
  function automatic logic at(input logic [12:0] a, input logic [12:0] o);
    at = (a[12:2] == o[12:2]);
  endfunction

  // -----------------------------------------------------------------------
  // Sub-blocks
  // -----------------------------------------------------------------------
  // The divider only runs while the engine is actually sampling.
  assign sampling = (state_q != la_pkg::ST_IDLE) &&
                    (state_q != la_pkg::ST_DONE);

  sample_tick #(
    .W       (RATE_W)
  ) u_tick (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .restart (run_q),
    .en      (sampling),
    .period  (rate_q),
    .tick    (tick)
  );

  trig_match #(
    .N    (NC)
  ) u_match (
    .cur  (ch_in),
    .prev (prev_q),
    .cond (trig_q),
    .hit  (hit)
  );

  // -----------------------------------------------------------------------
  // APB decode
  // -----------------------------------------------------------------------
  // Read data is fetched in the setup cycle so the access phase completes
  // with no wait state and prdata still comes from a flip-flop.
  assign setup  = psel && !penable;
  assign wr_acc = psel && penable && pready && pwrite;
  assign is_mem = paddr[la_pkg::MEM_SEL_BIT];
  assign mapped = is_mem ? !pwrite
                         : (at(paddr, la_pkg::OFS_CTRL) ||
                            at(paddr, la_pkg::OFS_RATE) ||
                            at(paddr, la_pkg::OFS_TRIG) ||
                            at(paddr, la_pkg::OFS_STATUS));

  // Record words are returned oldest first, so index 0 is the record start.
  always_comb begin
    rd_val = 32'h0000_0000;
    if (is_mem) begin
      rd_val[NC-1:0] = mem[paddr[AW+1:2] + start_q];
    end else if (at(paddr, la_pkg::OFS_CTRL)) begin
      rd_val[la_pkg::CTRL_POS_LSB +: 2] = pos_q;
    end else if (at(paddr, la_pkg::OFS_RATE)) begin
      rd_val[RATE_W-1:0] = rate_q;
    end else if (at(paddr, la_pkg::OFS_TRIG)) begin
      rd_val[3*NC-1:0] = trig_q;
    end else if (at(paddr, la_pkg::OFS_STATUS)) begin
      rd_val[la_pkg::STAT_BUSY_BIT] = capture_busy;
      rd_val[la_pkg::STAT_DONE_BIT] = capture_done;
      rd_val[la_pkg::STAT_ST_LSB +: 3] = state_q;
    end
  end

  // Bus answer flops.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (ce) begin
      pready <= setup;
      if (setup) begin
        pslverr <= !mapped;
        prdata  <= pwrite ? 32'h0000_0000 : rd_val;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // -----------------------------------------------------------------------
  // Configuration registers
  // -----------------------------------------------------------------------
  // Settings are taken at any time; changing them mid-capture is the
  // caller's risk, which is why run is a separate write.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_q  <= la_pkg::POS_RST;
      rate_q <= RATE_W'(la_pkg::RATE_RST);
      trig_q <= la_pkg::TRIG_RST;
    end else if (ce && wr_acc && !pslverr) begin
      if (at(paddr, la_pkg::OFS_CTRL)) begin
        pos_q <= pwdata[la_pkg::CTRL_POS_LSB +: 2];
      end
      if (at(paddr, la_pkg::OFS_RATE)) begin
        rate_q <= pwdata[RATE_W-1:0];
      end
      if (at(paddr, la_pkg::OFS_TRIG)) begin
        trig_q <= pwdata[3*NC-1:0];
      end
    end
  end

  // Run command pulse; the new position in the same write is already used.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q <= 1'b0;
    end else if (ce) begin
      run_q <= wr_acc && !pslverr && at(paddr, la_pkg::OFS_CTRL) &&
               pwdata[la_pkg::CTRL_RUN_BIT];
    end
  end

  // -----------------------------------------------------------------------
  // Capture sequencer
  // -----------------------------------------------------------------------
  assign dly_len = (pos_q == la_pkg::POS_DLY2) ? C_DLY2 : C_DLY1;

  // Decide the next state, counter and write strobe for this sample.
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    start_d = start_q;
    wr_en   = 1'b0;
    if (tick) begin
      case (state_q)
        la_pkg::ST_ARM: begin
          // Fill the half record that precedes the trigger.
          wr_en = 1'b1;
          cnt_d = cnt_q + C_ONE;
          if (cnt_q == C_PRE - C_ONE) begin
            state_d = la_pkg::ST_WAIT;
          end
        end
        la_pkg::ST_WAIT: begin
          // Centre mode keeps the ring rolling while it waits.
          wr_en = (pos_q == la_pkg::POS_CENTRE) ||
                  (hit && prev_ok_q && pos_q == la_pkg::POS_START);
          if (hit && prev_ok_q) begin
            case (pos_q)
              la_pkg::POS_START: begin
                cnt_d   = C_ONE;
                state_d = la_pkg::ST_STORE;
              end
              la_pkg::POS_CENTRE: begin
                start_d = wptr_q - A_PRE;
                cnt_d   = C_PRE + C_ONE;
                state_d = la_pkg::ST_STORE;
              end
              default: begin
                cnt_d   = C_ONE;
                state_d = la_pkg::ST_DELAY;
              end
            endcase
          end
        end
        la_pkg::ST_DELAY: begin
          if (cnt_q == dly_len) begin
            wr_en   = 1'b1;
            cnt_d   = C_ONE;
            state_d = la_pkg::ST_STORE;
          end else begin
            cnt_d = cnt_q + C_ONE;
          end
        end
        la_pkg::ST_STORE: begin
          wr_en = 1'b1;
          cnt_d = cnt_q + C_ONE;
          if (cnt_q == C_LAST) begin
            state_d = la_pkg::ST_DONE;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // State, counters and pointers; a run restarts from any state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= la_pkg::ST_IDLE;
      cnt_q   <= '0;
      start_q <= '0;
      wptr_q  <= '0;
    end else if (ce) begin
      if (run_q) begin
        state_q <= (pos_q == la_pkg::POS_CENTRE) ? la_pkg::ST_ARM
                                                  : la_pkg::ST_WAIT;
        cnt_q   <= '0;
        start_q <= '0;
        wptr_q  <= '0;
      end else begin
        state_q <= state_d;
        cnt_q   <= cnt_d;
        start_q <= start_d;
        if (wr_en) begin
          wptr_q <= wptr_q + A_ONE;
        end
      end
    end
  end

  // Previous sample for edge conditions; the first sample after run only
  // seeds it, so a stale value cannot fake an edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_q    <= '0;
      prev_ok_q <= 1'b0;
    end else if (ce) begin
      if (run_q) begin
        prev_ok_q <= 1'b0;
      end else if (tick) begin
        prev_q    <= ch_in;
        prev_ok_q <= 1'b1;
      end
    end
  end

  // -----------------------------------------------------------------------
  // Sample memory
  // -----------------------------------------------------------------------
  // No reset on the array: contents are only meaningful once done is set.
  always_ff @(posedge pclk) begin
    if (ce && wr_en && !run_q) begin
      mem[wptr_q] <= ch_in;
    end
  end

  // -----------------------------------------------------------------------
  // Status outputs
  // -----------------------------------------------------------------------
  // Both are registered copies of the sequencer state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_busy <= 1'b0;
      capture_done <= 1'b0;
    end else if (ce) begin
      if (run_q) begin
        capture_busy <= 1'b1;
        capture_done <= 1'b0;
      end else begin
        capture_busy <= (state_d != la_pkg::ST_IDLE) &&
                        (state_d != la_pkg::ST_DONE);
        capture_done <= (state_d == la_pkg::ST_DONE);
      end
    end
  end

endmodule

/* rtl/la_pkg.sv */
// Constants, register map and state type of the capture engine.
// Assumes a 20 MHz APB clock and three synchronous monitored inputs.
package la_pkg;

  // ---------------------------------------------------------------------
  // Sizes and timing
  // ---------------------------------------------------------------------
  localparam int NUM_CH       = 3;
  localparam int REC_LEN      = 1024;
  localparam int PRE_LEN      = REC_LEN / 2;
  localparam int DELAY1_SMP   = 1000;
  localparam int DELAY2_SMP   = 2000;
  localparam int CLK_HZ       = 20_000_000;
  localparam int RATE_HZ_DEF  = 1_000_000;
  localparam int DIV_DEF      = CLK_HZ / RATE_HZ_DEF;

  // ---------------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------------
  localparam logic [12:0] OFS_CTRL   = 13'h0000;
  localparam logic [12:0] OFS_RATE   = 13'h0004;
  localparam logic [12:0] OFS_TRIG   = 13'h0008;
  localparam logic [12:0] OFS_STATUS = 13'h000C;
  localparam int          MEM_SEL_BIT = 12;

  // CTRL fields.
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_POS_LSB = 1;

  // STATUS fields.
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_ST_LSB   = 4;

  // Trigger position choices.
  localparam logic [1:0] POS_START  = 2'h0;
  localparam logic [1:0] POS_CENTRE = 2'h1;
  localparam logic [1:0] POS_DLY1   = 2'h2;
  localparam logic [1:0] POS_DLY2   = 2'h3;

  // Per-channel trigger condition codes, three bits per channel.
  localparam int         COND_W     = 3;
  localparam logic [2:0] COND_IGN   = 3'h0;
  localparam logic [2:0] COND_HIGH  = 3'h1;
  localparam logic [2:0] COND_LOW   = 3'h2;
  localparam logic [2:0] COND_RISE  = 3'h3;
  localparam logic [2:0] COND_FALL  = 3'h4;

  // Reset values.
  localparam logic [15:0] RATE_RST = 16'(DIV_DEF);
  localparam logic [8:0]  TRIG_RST = 9'h000;
  localparam logic [1:0]  POS_RST  = POS_START;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ARM, ST_WAIT, ST_DELAY, ST_STORE, ST_DONE
  } cap_state_t;

endpackage

/* rtl/sample_tick.sv */
// Sample-rate divider: one tick every 'period' clock cycles.
// Assumes the period register is stable while a capture runs.
module sample_tick #(
  parameter int W = 16
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         ce,
  input  wire logic         restart,
  input  wire logic         en,
  input  wire logic [W-1:0] period,
  output logic              tick
);

  logic [W-1:0] cnt_q;

  // -----------------------------------------------------------------------
  // Divider
  // -----------------------------------------------------------------------
  // A period of zero or one ticks every cycle, so no setting can stall it.
  assign tick = en && (cnt_q == '0);

  // Count down from period-1; restart lines the first tick up with run.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
    end else if (ce) begin
      if (restart || !en || cnt_q == '0) begin
        cnt_q <= (period > W'(1)) ? period - W'(1) : '0;
      end else begin
        cnt_q <= cnt_q - W'(1);
      end
    end
  end

endmodule

/* rtl/trig_match.sv */
// Trigger evaluation over all channels for one sample.
// Assumes prev holds the sample taken one period before cur.
module trig_match #(
  parameter int N = 3
) (
  input  wire logic [N-1:0]   cur,
  input  wire logic [N-1:0]   prev,
  input  wire logic [3*N-1:0] cond,
  output logic                hit
);

  // -----------------------------------------------------------------------
  // Condition check
  // -----------------------------------------------------------------------
  function automatic logic chan_ok(input logic [2:0] c, input logic now,
                                   input logic was);
    case (c)
      la_pkg::COND_IGN:  chan_ok = 1'b1;
      la_pkg::COND_HIGH: chan_ok = now;
      la_pkg::COND_LOW:  chan_ok = !now;
      la_pkg::COND_RISE: chan_ok = now && !was;
      la_pkg::COND_FALL: chan_ok = !now && was;
      default:           chan_ok = 1'b1; // Unused codes act as ignore.
    endcase
  endfunction

  // Every channel must agree on the same sample.
  always_comb begin
    hit = 1'b1;
    for (int i = 0; i < N; i++) begin
      hit = hit & chan_ok(cond[3*i +: 3], cur[i], prev[i]);
    end
  end

endmodule
